// ### src/smcr_map.svh
// register offsets, field positions, module count and reset pulse length for the module control registers
`ifndef SMCR_MAP_SVH
`define SMCR_MAP_SVH
`define SMCR_CTRL_ADDR 5'h00
`define SMCR_BIT_RESET 15
`define SMCR_BIT_RSVD14 14
`define SMCR_BIT_SPEED_LSB 13
`define SMCR_BIT_AUTONEG_EN 12
`define SMCR_BIT_B11 11
`define SMCR_BIT_ISOLATE 10
`define SMCR_BIT_RESTART 9
`define SMCR_BIT_DUPLEX 8
`define SMCR_BIT_COLTEST 7
`define SMCR_BIT_SPEED_MSB 6
`define SMCR_BIT_UNIDIR 5
`define SMCR_NUM_MODULES 4
`define SMCR_RESET_PULSE_CYC 4'h4
`endif

// ### src/smcr_pkg.sv
// types for the module control register bank
package smcr_pkg;
    typedef struct packed {
        logic rsvd14;
        logic autoneg_en;
        logic bit11;
        logic isolate;
        logic unidir;
    } smcr_ctrl_t;

    typedef struct packed {
        logic module_reset;
        logic autoneg_restart;
        logic power_down;
        logic autoneg_en;
        logic isolate;
        logic tx_unidir;
    } smcr_out_t;
endpackage

// ### src/smcr_regs.sv
// four-module management control register bank at register address 0
// Summary of operation
// - Writing 1 to bit 15 resets the module, the bit self-clears and defaults to 0 in modules 1-3.
// - Module 0 has the same bit-15 reset control.
// - Bit 14 everywhere and bit 11 in modules 1-3 store and read back what was written, default 0.
// - Bit 13 reads 0 and bit 6 reads 1 for 1000 Mb/s, writes ignored.
// - Bit 12 is the read/write link_autoneg enable with default 1.
// - In module 0 bit 11 is power down, default 0, set by write and cleared only by module reset.
// - Bit 10 is the read/write isolate control with default 1.
// - Writing 1 to bit 9 restarts link_autoneg and the bit self-clears, default 0.
// - Bit 8 reads 1 for full duplex, writes ignored.
// - Bit 7 reads 0, collision test disabled.
// - Bit 5 is unidirectional enable, default 0, transmitting without link only while link_autoneg is off.
// - Bits 4 to 0 read zero and ignore writes.
// - Undefined register addresses read all zeros and ignore writes.
// - Each of the four modules has its own copy of the register.
`timescale 1ns/1ps
`include "smcr_map.svh"

module smcr_regs
(
    input wire logic SYS_CLK, // 40 MHz clock
    input wire logic RST_B, // async reset, active low
    input wire logic [1:0] MOD_SEL, // addressed module
    input wire logic [4:0] REG_ADDR, // register address
    input wire logic WR_EN, // one-cycle write strobe
    input wire logic [15:0] WR_DATA, // write data
    input wire logic RD_EN, // one-cycle read strobe
    output logic [15:0] RD_DATA, // read data, valid cycle after RD_EN
    output logic [3:0] MOD_RESET, // per module reset pulse
    output logic [3:0] AUTONEG_RESTART, // per module restart pulse
    output logic [3:0] AUTONEG_EN, // per module link_autoneg enable
    output logic [3:0] ISOLATE, // per module isolate
    output logic [3:0] TX_UNIDIR, // transmit without link
    output logic POWER_DOWN // module 0 power down
);
    smcr_pkg::smcr_ctrl_t ctrl_r [`SMCR_NUM_MODULES];
    logic [3:0] rst_cnt_r [`SMCR_NUM_MODULES];
    logic [3:0] restart_r;
    logic pd_r;
    logic [15:0] rd_nxt;
    logic [15:0] rd_r;
    logic hit;

    assign hit = (REG_ADDR == `SMCR_CTRL_ADDR);

    genvar g;
    generate
        for (g = 0; g < `SMCR_NUM_MODULES; g++)
        begin : gen_mod
            logic wr_me;
            assign wr_me = WR_EN && hit && (MOD_SEL == 2'(g));

            // reset counter: bit 15 reads 1 while the module is held in reset
            always_ff @(posedge SYS_CLK or negedge RST_B)
            begin
                if (!RST_B)
                    rst_cnt_r[g] <= 4'h0;
                else if (wr_me && WR_DATA[`SMCR_BIT_RESET])
                    rst_cnt_r[g] <= `SMCR_RESET_PULSE_CYC;
                else if (rst_cnt_r[g] != 4'h0)
                    rst_cnt_r[g] <= rst_cnt_r[g] - 4'h1;
            end

            always_ff @(posedge SYS_CLK or negedge RST_B)
            begin
                if (!RST_B)
                    ctrl_r[g] <= '{rsvd14: 1'b0, autoneg_en: 1'b1, bit11: 1'b0, isolate: 1'b1, unidir: 1'b0};
                else if (rst_cnt_r[g] == 4'h1)
                    ctrl_r[g] <= '{rsvd14: 1'b0, autoneg_en: 1'b1, bit11: 1'b0, isolate: 1'b1, unidir: 1'b0};
                else if (wr_me && rst_cnt_r[g] == 4'h0)
                begin
                    ctrl_r[g].rsvd14 <= WR_DATA[`SMCR_BIT_RSVD14];
                    ctrl_r[g].autoneg_en <= WR_DATA[`SMCR_BIT_AUTONEG_EN];
                    ctrl_r[g].bit11 <= (g == 0) ? 1'b0 : WR_DATA[`SMCR_BIT_B11];
                    ctrl_r[g].isolate <= WR_DATA[`SMCR_BIT_ISOLATE];
                    ctrl_r[g].unidir <= WR_DATA[`SMCR_BIT_UNIDIR];
                end
            end

            always_ff @(posedge SYS_CLK or negedge RST_B)
            begin
                if (!RST_B)
                    restart_r[g] <= 1'b0;
                else
                    restart_r[g] <= wr_me && WR_DATA[`SMCR_BIT_RESTART] && rst_cnt_r[g] == 4'h0;
            end
        end
    endgenerate

    // power down: write can only set it, module 0 reset clears it
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            pd_r <= 1'b0;
        else if (rst_cnt_r[0] == 4'h1)
            pd_r <= 1'b0;
        else if (WR_EN && hit && MOD_SEL == 2'h0 && WR_DATA[`SMCR_BIT_B11] && rst_cnt_r[0] == 4'h0)
            pd_r <= 1'b1;
    end

    always_comb
    begin
        rd_nxt = 16'h0000;
        if (hit)
        begin
            rd_nxt[`SMCR_BIT_RESET] = (rst_cnt_r[MOD_SEL] != 4'h0);
            rd_nxt[`SMCR_BIT_RSVD14] = ctrl_r[MOD_SEL].rsvd14;
            rd_nxt[`SMCR_BIT_SPEED_LSB] = 1'b0;
            rd_nxt[`SMCR_BIT_AUTONEG_EN] = ctrl_r[MOD_SEL].autoneg_en;
            rd_nxt[`SMCR_BIT_B11] = (MOD_SEL == 2'h0) ? pd_r : ctrl_r[MOD_SEL].bit11;
            rd_nxt[`SMCR_BIT_ISOLATE] = ctrl_r[MOD_SEL].isolate;
            rd_nxt[`SMCR_BIT_RESTART] = restart_r[MOD_SEL];
            rd_nxt[`SMCR_BIT_DUPLEX] = 1'b1;
            rd_nxt[`SMCR_BIT_COLTEST] = 1'b0;
            rd_nxt[`SMCR_BIT_SPEED_MSB] = 1'b1;
            rd_nxt[`SMCR_BIT_UNIDIR] = ctrl_r[MOD_SEL].unidir;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            rd_r <= 16'h0000;
        else if (RD_EN)
            rd_r <= rd_nxt;
    end
    assign RD_DATA = rd_r;

    // registered outputs
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            MOD_RESET <= 4'h0;
            AUTONEG_RESTART <= 4'h0;
            AUTONEG_EN <= 4'hf;
            ISOLATE <= 4'hf;
            TX_UNIDIR <= 4'h0;
            POWER_DOWN <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < `SMCR_NUM_MODULES; i++)
            begin
                MOD_RESET[i] <= (rst_cnt_r[i] != 4'h0);
                AUTONEG_RESTART[i] <= restart_r[i];
                AUTONEG_EN[i] <= ctrl_r[i].autoneg_en;
                ISOLATE[i] <= ctrl_r[i].isolate;
                TX_UNIDIR[i] <= ctrl_r[i].unidir && !ctrl_r[i].autoneg_en;
            end
            POWER_DOWN <= pd_r;
        end
    end

    property p_reset_clears_pd;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (rst_cnt_r[0] == 4'h1) |=> !pd_r;
    endproperty
    a_reset_clears_pd: assert property (p_reset_clears_pd) else $error("power down not cleared by reset");

    property p_pd_sticky;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (pd_r && rst_cnt_r[0] != 4'h1) |=> pd_r;
    endproperty
    a_pd_sticky: assert property (p_pd_sticky) else $error("power down cleared without reset");

    property p_restart_pulse;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (restart_r[3] && !(WR_EN && hit && MOD_SEL == 2'h3 && WR_DATA[`SMCR_BIT_RESTART])) |=> !restart_r[3];
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart not self clearing");

    property p_reset_len;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (WR_EN && hit && MOD_SEL == 2'h1 && WR_DATA[15]) |=> ##1 MOD_RESET[1] [*4] ##1 !MOD_RESET[1];
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("module reset length wrong");

    property p_unmapped_zero;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (RD_EN && !hit) |=> (RD_DATA == 16'h0000);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_const_bits;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (RD_EN && hit) |=> (RD_DATA[8:6] == 3'h5 && RD_DATA[13] == 1'b0 && RD_DATA[4:0] == 5'h00);
    endproperty
    a_const_bits: assert property (p_const_bits) else $error("constant bits wrong");

    property p_defaults_after_reset;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (rst_cnt_r[2] == 4'h1) |=> ##1 (AUTONEG_EN[2] && ISOLATE[2] && !TX_UNIDIR[2]);
    endproperty
    a_defaults_after_reset: assert property (p_defaults_after_reset) else $error("defaults not restored");

    property p_unidir;
        @(posedge SYS_CLK) disable iff (!RST_B)
        TX_UNIDIR[3] |-> $past(ctrl_r[3].unidir) && !$past(ctrl_r[3].autoneg_en);
    endproperty
    a_unidir: assert property (p_unidir) else $error("unidirectional gating wrong");

    property p_ctrl_frozen;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (rst_cnt_r[1] > 4'h1) |=> $stable(ctrl_r[1]);
    endproperty
    a_ctrl_frozen: assert property (p_ctrl_frozen) else $error("control changed during module reset");

    property p_levels_match_read;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (RD_EN && hit && MOD_SEL == 2'h2) |=> (RD_DATA[12] == AUTONEG_EN[2] && RD_DATA[10] == ISOLATE[2]);
    endproperty
    a_levels_match_read: assert property (p_levels_match_read) else $error("control levels differ from read");

    property p_pd_matches_read;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (RD_EN && hit && MOD_SEL == 2'h0) |=> (RD_DATA[11] == POWER_DOWN);
    endproperty
    a_pd_matches_read: assert property (p_pd_matches_read) else $error("power down differs from read");

    property p_mod0_reset_out;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (WR_EN && hit && MOD_SEL == 2'h0 && WR_DATA[`SMCR_BIT_RESET]) |=> ##1 MOD_RESET[0];
    endproperty
    a_mod0_reset_out: assert property (p_mod0_reset_out) else $error("module 0 reset not raised");
endmodule

// ### dv/smcr_sta.sv
// station management model issuing register accesses
`timescale 1ns/1ps
module smcr_sta
(
    input wire logic clk, // system clock
    input wire logic [15:0] rd_data, // read data
    output logic [1:0] sel, // addressed module
    output logic [4:0] adr, // register address
    output logic we, // write strobe
    output logic [15:0] wd, // write data
    output logic re // read strobe
);
    int idle = 0; // gap before each access
    initial
    begin
        sel = 2'h0;
        adr = 5'h00;
        we = 1'b0;
        wd = 16'h0000;
        re = 1'b0;
    end
    task automatic wr(input logic [1:0] m, input logic [4:0] a, input logic [15:0] d);
        repeat (idle) @(posedge clk);
        @(posedge clk);
        sel <= m;
        adr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        wd <= ~d; // no stale data left behind
    endtask
    task automatic rd(input logic [1:0] m, input logic [4:0] a, output logic [15:0] q);
        repeat (idle) @(posedge clk);
        @(posedge clk);
        sel <= m;
        adr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        #1;
        q = rd_data;
    endtask
endmodule

// ### dv/tb.sv
// self-checking bench for the module control register bank
`timescale 1ns/1ps
module tb;
    logic clk, rst_b, we, re, pd;
    logic [1:0] sel;
    logic [4:0] adr;
    logic [15:0] wd, rdd, q;
    logic [3:0] mrst, rst_p, ane, iso, uni;
    int miscompares = 0;
    int compares = 0;
    smcr_regs u_dut (.SYS_CLK(clk), .RST_B(rst_b), .MOD_SEL(sel), .REG_ADDR(adr), .WR_EN(we), .WR_DATA(wd),
        .RD_EN(re), .RD_DATA(rdd), .MOD_RESET(mrst), .AUTONEG_RESTART(rst_p), .AUTONEG_EN(ane), .ISOLATE(iso),
        .TX_UNIDIR(uni), .POWER_DOWN(pd));
    smcr_sta u_sta (.clk(clk), .rd_data(rdd), .sel(sel), .adr(adr), .we(we), .wd(wd), .re(re));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_defaults();
        for (int m = 0; m < 4; m++)
        begin
            u_sta.rd(m[1:0], 5'h00, q);
            chk(q, 16'h1540);
        end
        chk({ane, iso, uni, 3'h0, pd}, 16'hff00);
    endtask
    task automatic t_fields();
        u_sta.wr(2'h1, 5'h00, 16'h283f);
        u_sta.rd(2'h1, 5'h00, q);
        chk(q, 16'h0960);
        chk({ane, iso, uni, 3'h0, pd}, 16'hdd20);
        u_sta.idle = 3;
        u_sta.wr(2'h1, 5'h00, 16'h5000);
        u_sta.rd(2'h1, 5'h00, q);
        u_sta.idle = 0;
        chk(q, 16'h5140);
        chk({ane, iso, uni, 4'h0}, 16'hfd00);
    endtask
    task automatic t_power_reset();
        u_sta.wr(2'h0, 5'h00, 16'h1d40);
        u_sta.wr(2'h0, 5'h00, 16'h1540);
        u_sta.rd(2'h0, 5'h00, q);
        chk(q, 16'h1d40);
        chk({15'h0000, pd}, 16'h0001);
        u_sta.wr(2'h0, 5'h00, 16'h8000);
        repeat (3) @(posedge clk);
        #1;
        chk({12'h000, mrst}, 16'h0001);
        repeat (8) @(posedge clk);
        u_sta.rd(2'h0, 5'h00, q);
        chk(q, 16'h1540);
        chk({15'h0000, pd}, 16'h0000);
        u_sta.wr(2'h1, 5'h00, 16'h8000);
        u_sta.rd(2'h1, 5'h00, q);
        chk({15'h0000, q[15]}, 16'h0001);
        repeat (10) @(posedge clk);
        u_sta.rd(2'h1, 5'h00, q);
        chk(q, 16'h1540);
    endtask
    task automatic t_restart_unmapped();
        int n;
        n = 0;
        u_sta.wr(2'h3, 5'h00, 16'h1340);
        repeat (6)
        begin
            @(posedge clk);
            #1;
            n += (rst_p === 4'h8);
        end
        chk(n[15:0], 16'h0001);
        u_sta.rd(2'h3, 5'h00, q);
        chk(q, 16'h1140);
        u_sta.wr(2'h2, 5'h01, 16'hffff);
        u_sta.wr(2'h2, 5'h1f, 16'h8200);
        u_sta.rd(2'h2, 5'h01, q);
        chk(q, 16'h0000);
        u_sta.rd(2'h2, 5'h00, q);
        chk(q, 16'h1540);
        chk({12'h000, mrst | rst_p}, 16'h0000);
    endtask
    task automatic t_unidir_reset();
        u_sta.wr(2'h3, 5'h00, 16'h0020);
        repeat (2) @(posedge clk);
        #1;
        chk({ane, iso, uni, 4'h0}, 16'h7780);
        u_sta.wr(2'h2, 5'h00, 16'h8020);
        repeat (2) @(posedge clk);
        #1;
        chk({ane, uni, mrst, 4'h0}, 16'h3c40);
        repeat (8) @(posedge clk);
        #1;
        chk({ane, iso, uni, 4'h0}, 16'h7780);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        rst_b = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_defaults();
        t_fields();
        t_power_reset();
        t_restart_unmapped();
        t_unidir_reset();
        complete_run();
    end
endmodule
